//--- logic/ldh_i2c_host.sv
`timescale 1ns/10ps
// Overview of operation
// - Select pin on data line gives bits 10
// - Single command: start, address, one byte, stop
// - Compound command: command byte then parameter bytes
// - Single RAM write: command, location, data, stop
// - RAM read: set location, repeated start, read
// - Acknowledge to continue, last byte NACK, stop
// - Frame status: command, repeated start, read
// - Loop status: command, repeated start, read
// - Function flags: command, repeated start, read
// - Master reads only whole bytes
// - Eight bits, MSB first, then acknowledge
module ldh_i2c_host #(
   parameter int FIFO_DEPTH  = ldh_pkg::TX_DEPTH,   // Transmit queue depth
   parameter int QUARTER_CYC = ldh_pkg::QUARTER_CYC // Clocks per quarter bit, below 257
) (
   input  wire logic                   mclk,          // System clock, 100 MHz
   input  wire logic                   rst_n,         // Synchronous reset, active low
   input  wire logic                   cmd_valid,     // Start a transfer
   output logic                        cmd_ready,     // Engine idle, command taken
   input  wire ldh_pkg::ldh_strap_e    cmd_strap,     // Strap of the target device
   input  wire logic                   cmd_broadcast, // Use the all-drivers address
   input  wire logic [7:0]             cmd_wr_len,    // Bytes to write from queue
   input  wire logic [7:0]             cmd_rd_len,    // Bytes to read back
   input  wire logic [7:0]             tx_data,       // Byte for the write queue
   input  wire logic                   tx_valid,      // Byte offered
   output logic                        tx_ready,      // Queue has room
   output logic [7:0]                  rx_data,       // Byte read from device
   output logic                        rx_valid,      // One-cycle pulse per byte read
   output logic                        done,          // One-cycle pulse after stop
   output logic                        nack_err,      // Device refused a byte
   output logic                        busy,          // Transfer in progress
   input  wire logic                   scl_in,        // Clock line level
   output logic                        scl_out,       // Clock line drive value
   output logic                        scl_oe_n,      // Clock line pulled low when 0
   input  wire logic                   sda_in,        // Data line level
   output logic                        sda_out,       // Data line drive value
   output logic                        sda_oe_n       // Data line pulled low when 0
);
   typedef struct packed {
      ldh_pkg::ldh_state_e            state;
      logic [1:0]                     ph;
      logic [3:0]                     bitn;
      logic [7:0]                     shift;
      logic [7:0]                     wr_left;
      logic [7:0]                     rd_left;
      logic                           rd_mode;
      logic                           is_addr;
      logic                           need_load;
      logic [6:0]                     addr7;
      logic [ldh_pkg::DIV_W-1:0]      div;
      logic                           scl_oe_n;
      logic                           sda_oe_n;
      logic [7:0]                     rx_data;
      logic                           rx_valid;
      logic                           done;
      logic                           nack_err;
      logic                           scl_m;
      logic                           scl_s;
      logic                           sda_m;
      logic                           sda_s;
   } ldh_host_s;

   // Reload value of the quarter-bit divider
   localparam logic [ldh_pkg::DIV_W-1:0] RELOAD = ldh_pkg::DIV_W'(QUARTER_CYC - 1);

   ldh_host_s st;
   ldh_host_s next_st;
   logic      tick;
   logic      adv;
   logic      reading;
   logic      data_bit;

   ldh_stream_if #(.WIDTH(ldh_pkg::BYTE_W)) tx_q ();

   // ****************************************************************
   // Transmit queue
   // ****************************************************************
   // The engine stalls with the clock low while the queue is empty
   ldh_fifo #(
      .WIDTH (ldh_pkg::BYTE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (mclk),
      .rst_n    (rst_n),
      .in_data  (tx_data),
      .in_valid (tx_valid),
      .in_ready (tx_ready),
      .out      (tx_q.src)
   );

   // Low address bits the device takes from its strap
   function automatic logic [1:0] strap_bits(input ldh_pkg::ldh_strap_e s);
      unique case (s)
         ldh_pkg::STRAP_GND: strap_bits = ldh_pkg::AB_GND;
         ldh_pkg::STRAP_VDD: strap_bits = ldh_pkg::AB_VDD;
         ldh_pkg::STRAP_SCL: strap_bits = ldh_pkg::AB_SCL;
         ldh_pkg::STRAP_SDA: strap_bits = ldh_pkg::AB_SDA;
      endcase
   endfunction

   // ****************************************************************
   // Bus engine
   // ****************************************************************
   // Quarter-bit phases; the high phase waits for the line itself to rise,
   // which honours a slave that stretches the clock
   always_comb begin
      next_st          = st;
      tx_q.ready       = 1'b0;
      next_st.scl_m    = scl_in;
      next_st.scl_s    = st.scl_m;
      next_st.sda_m    = sda_in;
      next_st.sda_s    = st.sda_m;
      next_st.rx_valid = 1'b0;
      next_st.done     = 1'b0;
      tick             = (st.div == '0);
      next_st.div      = tick ? RELOAD : st.div - 1'b1;
      adv              = tick && ((st.ph != 2'd3) || st.scl_s);
      reading          = st.rd_mode && !st.is_addr;
      data_bit         = st.need_load ? tx_q.data[7] : st.shift[7];
      unique case (st.state)
         ldh_pkg::ST_IDLE: begin
            if (cmd_valid) begin
               next_st.state    = ldh_pkg::ST_START;
               next_st.ph       = 2'd1;      // Lines already high, skip the low phase
               next_st.addr7    = cmd_broadcast ? ldh_pkg::BCAST_ADDR
                                : {ldh_pkg::DEV_ADDR_BASE, strap_bits(cmd_strap)};
               next_st.wr_left  = cmd_wr_len;
               next_st.rd_left  = cmd_rd_len;
               next_st.rd_mode  = (cmd_wr_len == 8'h00) && (cmd_rd_len != 8'h00);
               next_st.nack_err = 1'b0;
               next_st.bitn     = 4'h0;
            end
         end
         ldh_pkg::ST_START: begin
            if (adv) begin
               next_st.ph = st.ph + 2'd1;
               unique case (st.ph)
                  2'd0: next_st.scl_oe_n = 1'b0;
                  2'd1: next_st.sda_oe_n = 1'b1;
                  2'd2: next_st.scl_oe_n = 1'b1;
                  2'd3: begin
                     next_st.sda_oe_n  = 1'b0;
                     next_st.state     = ldh_pkg::ST_BYTE;
                     next_st.is_addr   = 1'b1;
                     next_st.need_load = 1'b0;
                     next_st.shift     = {st.addr7, st.rd_mode ? ldh_pkg::DIR_READ
                                                               : ldh_pkg::DIR_WRITE};
                  end
               endcase
            end
         end
         ldh_pkg::ST_BYTE: begin
            if (adv) begin
               unique case (st.ph)
                  2'd0: begin
                     next_st.scl_oe_n = 1'b0;
                     next_st.ph       = 2'd1;
                  end
                  2'd1: begin
                     // Data changes only while the clock is low
                     if (!st.need_load || tx_q.valid) begin
                        next_st.ph = 2'd2;
                        if (st.need_load) begin
                           next_st.shift     = tx_q.data;
                           tx_q.ready        = 1'b1;
                           next_st.need_load = 1'b0;
                           next_st.wr_left   = st.wr_left - 8'h01;
                        end
                        if (st.bitn == 4'd8) begin
                           next_st.sda_oe_n = !(reading && (st.rd_left != 8'h01));
                        end else begin
                           next_st.sda_oe_n = reading ? 1'b1 : data_bit;
                        end
                     end
                  end
                  2'd2: begin
                     next_st.scl_oe_n = 1'b1;
                     next_st.ph       = 2'd3;
                  end
                  2'd3: begin
                     next_st.ph = 2'd0;
                     if (st.bitn != 4'd8) begin
                        next_st.bitn  = st.bitn + 4'd1;
                        next_st.shift = {st.shift[6:0], reading ? st.sda_s : 1'b0};
                     end else begin
                        next_st.bitn = 4'h0;
                        if (!reading && st.sda_s) begin
                           next_st.nack_err = 1'b1;    // Refused, give up the bus
                           next_st.state    = ldh_pkg::ST_STOP;
                        end else if (reading) begin
                           next_st.rx_data  = st.shift;
                           next_st.rx_valid = 1'b1;
                           next_st.rd_left  = st.rd_left - 8'h01;
                           if (st.rd_left == 8'h01) begin
                              next_st.state = ldh_pkg::ST_STOP;
                           end
                        end else if (st.is_addr && st.rd_mode) begin
                           next_st.is_addr = 1'b0;
                        end else if (st.wr_left != 8'h00) begin
                           next_st.is_addr   = 1'b0;
                           next_st.need_load = 1'b1;
                        end else if (st.rd_left != 8'h00) begin
                           next_st.rd_mode = 1'b1;
                           next_st.state   = ldh_pkg::ST_START;
                        end else begin
                           next_st.state = ldh_pkg::ST_STOP;
                        end
                     end
                  end
               endcase
            end
         end
         ldh_pkg::ST_STOP: begin
            if (adv) begin
               next_st.ph = st.ph + 2'd1;
               unique case (st.ph)
                  2'd0: next_st.scl_oe_n = 1'b0;
                  2'd1: next_st.sda_oe_n = 1'b0;
                  2'd2: next_st.scl_oe_n = 1'b1;
                  2'd3: begin
                     next_st.sda_oe_n = 1'b1;
                     next_st.state    = ldh_pkg::ST_IDLE;
                     next_st.done     = 1'b1;
                  end
               endcase
            end
         end
      endcase
   end

   // Both lines released and synchronisers idle-high out of reset
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st          <= '0;
         st.state    <= ldh_pkg::ST_IDLE;
         st.scl_oe_n <= 1'b1;
         st.sda_oe_n <= 1'b1;
         st.scl_m    <= 1'b1;
         st.scl_s    <= 1'b1;
         st.sda_m    <= 1'b1;
         st.sda_s    <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Open-drain: only ever pull low
   assign scl_out   = 1'b0;
   assign sda_out   = 1'b0;
   assign scl_oe_n  = st.scl_oe_n;
   assign sda_oe_n  = st.sda_oe_n;
   assign cmd_ready = (st.state == ldh_pkg::ST_IDLE);
   assign busy      = !cmd_ready;
   assign rx_data   = st.rx_data;
   assign rx_valid  = st.rx_valid;
   assign done      = st.done;
   assign nack_err  = st.nack_err;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   chk_start_edge: assert property (
      (st.state == ldh_pkg::ST_START && st.ph == 2'd3 && adv)
         |=> (st.state == ldh_pkg::ST_BYTE && !st.sda_oe_n && st.scl_oe_n))
      else $error("start condition not formed");
   chk_strap_sda: assert property (
      (cmd_valid && cmd_ready && !cmd_broadcast && cmd_strap == ldh_pkg::STRAP_SDA)
         |=> st.addr7 == 7'h66)
      else $error("data-line strap address wrong");
   chk_sda_high_hold: assert property (
      (st.state == ldh_pkg::ST_BYTE && st.ph == 2'd3) |-> $stable(st.sda_oe_n))
      else $error("data moved while clock high");
   chk_last_nack: assert property (
      (st.state == ldh_pkg::ST_BYTE && reading && st.bitn == 4'd8 && st.ph == 2'd3
         && st.rd_left == 8'h01) |-> st.sda_oe_n)
      else $error("last read byte was acknowledged");
   chk_more_ack: assert property (
      (st.state == ldh_pkg::ST_BYTE && reading && st.bitn == 4'd8 && st.ph == 2'd3
         && st.rd_left > 8'h01) |-> !st.sda_oe_n)
      else $error("middle read byte not acknowledged");
   chk_stop_after_nack: assert property (
      (st.state == ldh_pkg::ST_BYTE && reading && st.bitn == 4'd8 && st.ph == 2'd3
         && adv && st.rd_left == 8'h01) |=> (st.state == ldh_pkg::ST_STOP && st.ph == 2'd0))
      else $error("no stop after final read byte");
   chk_restart_read: assert property (
      (st.state == ldh_pkg::ST_BYTE && !st.rd_mode && st.bitn == 4'd8 && st.ph == 2'd3
         && adv && !st.sda_s && st.wr_left == 8'h00 && st.rd_left != 8'h00)
         |=> (st.state == ldh_pkg::ST_START && st.rd_mode && st.ph == 2'd0))
      else $error("no repeated start before read");
   chk_rx_whole: assert property (
      st.rx_valid |-> ($past(st.bitn) == 4'd8 && $past(st.state) == ldh_pkg::ST_BYTE))
      else $error("partial byte delivered");
   chk_done_released: assert property (
      st.done |-> ($past(st.state) == ldh_pkg::ST_STOP && st.sda_oe_n && st.scl_oe_n))
      else $error("done without a stop");

endmodule // ldh_i2c_host

//--- logic/ldh_pkg.sv
package ldh_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 10;        // System clock period
   localparam int SCL_PERIOD_NS = 10000;     // Serial clock period, 100 kHz
   // A quarter of a serial bit, rounded down so the bus never runs slow
   localparam int QUARTER_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   localparam int DIV_W         = 8;
   localparam logic [DIV_W-1:0] QUARTER_RELOAD = DIV_W'(QUARTER_CYC - 1);

   // ****************************************************************
   // Addressing
   // ****************************************************************
   localparam logic [4:0] DEV_ADDR_BASE = 5'h19;   // Fixed upper five bits
   localparam logic [6:0] BCAST_ADDR    = 7'h2E;   // Address every driver answers
   localparam logic [1:0] AB_GND        = 2'h0;    // Low bits, select pin to ground
   localparam logic [1:0] AB_VDD        = 2'h3;    // Low bits, select pin to supply
   localparam logic [1:0] AB_SCL        = 2'h1;    // Low bits, select pin to clock line
   localparam logic [1:0] AB_SDA        = 2'h2;    // Low bits, select pin to data line
   localparam logic       DIR_WRITE     = 1'b0;
   localparam logic       DIR_READ      = 1'b1;

   // ****************************************************************
   // Buffering and types
   // ****************************************************************
   localparam int BYTE_W   = 8;
   localparam int TX_DEPTH = 32;

   // How the device's address-select pin is strapped
   typedef enum logic [1:0] {
      STRAP_GND = 2'b00,
      STRAP_VDD = 2'b01,
      STRAP_SCL = 2'b10,
      STRAP_SDA = 2'b11
   } ldh_strap_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_BYTE  = 2'b10,
      ST_STOP  = 2'b11
   } ldh_state_e;

endpackage

//--- logic/ldh_stream_if.sv
`timescale 1ns/10ps
// Valid/ready byte stream between the transmit queue and the bus engine
interface ldh_stream_if #(
   parameter int WIDTH = 8
);
   logic [WIDTH-1:0] data;
   logic             valid;
   logic             ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

//--- logic/ldh_fifo.sv
`timescale 1ns/10ps
module ldh_fifo #(
   parameter int WIDTH = 8,                 // Word width
   parameter int DEPTH = 32                 // Words in storage, power of two
) (
   input  wire logic             clk,       // System clock
   input  wire logic             rst_n,     // Synchronous reset, active low
   input  wire logic [WIDTH-1:0] in_data,   // Word to store
   input  wire logic             in_valid,  // Word offered
   output logic                  in_ready,  // Room for a word
   ldh_stream_if.src             out        // Head of queue
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0]    wptr;
      logic [AW-1:0]    rptr;
      logic [AW:0]      cnt;
      logic             out_v;
      logic [WIDTH-1:0] out_d;
   } ldh_fifo_s;

   ldh_fifo_s        st;
   ldh_fifo_s        next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             load;

   // ****************************************************************
   // Queue control
   // ****************************************************************
   // Head word lives in a register so the reader never sees a raw array read
   always_comb begin
      push    = in_valid && in_ready;
      load    = (st.cnt != '0) && (!st.out_v || out.ready);
      next_st = st;
      if (push) begin
         next_st.wptr = st.wptr + 1'b1;
      end
      if (load) begin
         next_st.rptr  = st.rptr + 1'b1;
         next_st.out_d = mem[st.rptr];
         next_st.out_v = 1'b1;
      end else if (out.ready) begin
         next_st.out_v = 1'b0;
      end
      next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
   end

   // Full only counts the array; the head register is one word of slack
   assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
   assign out.data  = st.out_d;
   assign out.valid = st.out_v;

   // Storage carries no reset, it is never read before being written
   always_ff @(posedge clk) begin
      if (push) begin
         mem[st.wptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule // ldh_fifo

//--- testbench/ldh_dev_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Behavioural serial port of the LED driver, binary mode, type 3
// ****************************************************************
module ldh_dev_model #(
   parameter logic [1:0] LOW_BITS = 2'h2,     // Strap bits, select pin on data line
   parameter logic [7:0] LIMIT    = 8'h1F,    // Memory limit of mode and type
   parameter logic [7:0] DUMMY    = 8'hC3     // Sent when no location was set
) (
   input  wire logic scl,                     // Clock line level
   input  wire logic sda,                     // Data line level
   output logic      sda_pull_n               // Pulls data line low when 0
);
   logic [7:0] mem [0:255];
   logic [7:0] sh, out, ptr;
   logic       act, rd, hdr, ack_m, set;
   int         n, widx;
   initial begin
      sda_pull_n = 1'b1;
      act = 1'b0;
      set = 1'b0;
      ptr = 8'h00;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
   end
   // START and repeated START are alike; n starts at -1 for the falling clock
   always @(negedge sda) if (scl === 1'b1) begin
      act = 1'b1;
      hdr = 1'b1;
      rd = 1'b0;
      n = -1;
      widx = 0;
   end
   // STOP frees the port
   always @(posedge sda) if (scl === 1'b1) begin
      act = 1'b0;
      sda_pull_n = 1'b1;
   end
   // Data is sampled while the clock is high, MSB first
   always @(posedge scl) if (act) begin
      if (n < 8 && !(rd && !hdr)) sh = {sh[6:0], sda};
      if (n == 8 && rd && !hdr) ack_m = !sda;
   end
   // The line only changes while the clock is low
   always @(negedge scl) if (act) begin
      n = n + 1;
      if (n == 8 && hdr) begin
         if (sh[7:1] == {5'b11001, LOW_BITS} || sh[7:1] == 7'b0101110) begin
            sda_pull_n = 1'b0;
            rd = sh[0];
         end else act = 1'b0;
      end else if (n == 8 && !rd) begin
         sda_pull_n = 1'b0;
         // Any command byte is taken as one that sets a location
         if (widx == 0) set = 1'b0;
         else if (widx == 1 && sh <= LIMIT) begin
            ptr = sh;
            set = 1'b1;
         end else if (widx > 1) begin
            mem[ptr] = sh;
            ptr = (ptr == LIMIT) ? 8'h00 : ptr + 8'h01;
         end
         widx = widx + 1;
      end else if (n == 8) sda_pull_n = 1'b1;
      else if (n == 9) begin
         n = 0;
         sda_pull_n = 1'b1;
         if (rd && (hdr || ack_m)) begin
            // One wrap rule serves memory, status and detection pointers
            if (!hdr) ptr = (ptr == LIMIT) ? 8'h00 : ptr + 8'h01;
            out = set ? mem[ptr] : DUMMY;
            sda_pull_n = out[7];
         end else if (rd) act = 1'b0;
         hdr = 1'b0;
      end else if (rd && !hdr && n > 0) sda_pull_n = out[7-n];
   end
endmodule // ldh_dev_model

//--- testbench/led_driver_i2c_slave_access_bench.sv
`timescale 1ns/10ps
module led_driver_i2c_slave_access_bench;
   typedef struct {
      ldh_pkg::ldh_strap_e strap;
      logic                bc;
      logic [7:0]          wr, rd;
      logic                nack;
      logic [7:0]          rx0, rx1;
   } ldh_row_s;
   logic                mclk, rst_n, cmd_valid, cmd_broadcast, tx_valid;
   ldh_pkg::ldh_strap_e cmd_strap;
   logic [7:0]          cmd_wr_len, cmd_rd_len, tx_data, rx_data;
   logic                cmd_ready, tx_ready, rx_valid, done, nack_err, busy;
   logic                scl_out, scl_oe_n, sda_out, sda_oe_n, dev_pull_n;
   int                  miscompares, n_compared;
   logic [7:0]          rxq[$];
   ldh_row_s            rows[4];
   logic [7:0]          txb[5] = '{8'h80, 8'h1F, 8'h3C, 8'h80, 8'h1F};
   // Open-drain lines with pull-ups; host alone drives the clock
   wire logic scl_line = scl_oe_n ? 1'b1 : scl_out;
   wire logic sda_line = (sda_oe_n ? 1'b1 : sda_out) & dev_pull_n;
   // Short quarter bit keeps the run brief; protocol timing scales with it
   ldh_i2c_host #(.QUARTER_CYC(25)) uut (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready),
      .cmd_strap(cmd_strap), .cmd_broadcast(cmd_broadcast), .cmd_wr_len(cmd_wr_len),
      .cmd_rd_len(cmd_rd_len), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_data(rx_data), .rx_valid(rx_valid), .done(done), .nack_err(nack_err), .busy(busy),
      .scl_in(scl_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n));
   ldh_dev_model #(.LOW_BITS(2'h2)) dev (.scl(scl_line), .sda(sda_line),
      .sda_pull_n(dev_pull_n));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Collect every byte read back
   always @(negedge mclk) if (rx_valid === 1'b1) rxq.push_back(rx_data);
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Command is held through the edge where the idle engine takes it
   task automatic run(input ldh_row_s r);
      rxq.delete();
      cmd_strap = r.strap;
      cmd_broadcast = r.bc;
      cmd_wr_len = r.wr;
      cmd_rd_len = r.rd;
      cmd_valid = 1'b1;
      @(negedge mclk);
      cmd_valid = 1'b0;
      for (int i = 0; i < 20000 && done !== 1'b1; i++) @(negedge mclk);
      check(done, 1'b1);
   endtask
   initial begin
      {cmd_valid, cmd_broadcast, tx_valid, rst_n} = 4'h0;
      cmd_strap = ldh_pkg::STRAP_GND;
      {cmd_wr_len, cmd_rd_len, tx_data} = 24'h000000;
      miscompares = 0;
      n_compared = 0;
      rows[0] = '{ldh_pkg::STRAP_SDA, 1'b0, 8'h00, 8'h01, 1'b0, 8'hC3, 8'h00};
      rows[1] = '{ldh_pkg::STRAP_VDD, 1'b0, 8'h00, 8'h00, 1'b1, 8'h00, 8'h00};
      rows[2] = '{ldh_pkg::STRAP_GND, 1'b1, 8'h03, 8'h00, 1'b0, 8'h00, 8'h00};
      rows[3] = '{ldh_pkg::STRAP_SDA, 1'b0, 8'h02, 8'h02, 1'b0, 8'h3C, 8'hA5};
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      // Queue all write bytes up front; commands pop them in order
      foreach (txb[j]) begin
         tx_data = txb[j];
         tx_valid = 1'b1;
         @(negedge mclk);
      end
      tx_valid = 1'b0;
      check({tx_ready, scl_out, sda_out}, 8'h04);
      foreach (rows[k]) begin
         run(rows[k]);
         check(nack_err, rows[k].nack);
         check(8'(rxq.size()), rows[k].rd);
         if (rows[k].rd > 0) check(rxq.size() > 0 ? rxq[0] : 8'h00, rows[k].rx0);
         if (rows[k].rd > 1) check(rxq.size() > 1 ? rxq[1] : 8'h00, rows[k].rx1);
      end
      // Reset in mid-transfer must drop the lines and free the engine
      cmd_broadcast = 1'b1;
      cmd_valid = 1'b1;
      @(negedge mclk);
      cmd_valid = 1'b0;
      repeat (3000) @(negedge mclk);
      check(busy, 1'b1);
      rst_n = 1'b0;
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      @(negedge mclk);
      check({busy, scl_oe_n, sda_oe_n, cmd_ready, nack_err}, 8'h0E);
      run('{ldh_pkg::STRAP_GND, 1'b1, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00});
      check(nack_err, 1'b0);
      close_out();
   end
   // Fourteen bytes of about 900 cycles each, the reset wait, plus slack
   initial begin
      #400000;
      miscompares++;
      close_out();
   end
endmodule // led_driver_i2c_slave_access_bench
